// ===== hw/cfg_seq_pkg.sv
/*
  Constants shared by the configuration output sequencer and its TAP.
  Assumes a single 40 MHz clock domain; pins are synchronised inside.
*/
`default_nettype none
package cfg_seq_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int REV_W = 2;
  localparam int REV_N = 4;
  localparam int MEM_DEPTH = 1 << ADDR_W;
  localparam logic [REV_W-1:0] REV_CTRL_RESET = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam int SYNC_STAGES = 2;
  localparam int TAP_IR_W = 4;
  localparam logic [TAP_IR_W-1:0] TAP_IR_RESET = 4'h1;
  localparam logic [TAP_IR_W-1:0] TAP_IR_BYPASS = 4'hf;
  localparam logic [TAP_IR_W-1:0] TAP_IR_CAPTURE = 4'h1;
  // Time from data fetch to ready under decompression, in ns; rounded up to clk cycles below
  localparam int DECOMP_NS = 75;
  localparam int CLK_NS = 25;
  localparam int DECOMP_CYC = (DECOMP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] DECOMP_CYC_W = 4'(DECOMP_CYC);
endpackage : cfg_seq_pkg
`default_nettype wire

// ===== hw/jtag_tap.sv
/*
  Small TAP controller with instruction and bypass registers.
  Assumes tck, tms and tdi are already synchronised to clk.
*/
`default_nettype none
module jtag_tap
  import cfg_seq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Test port, synchronised
  input wire logic tck_s,
  input wire logic tms_s,
  input wire logic tdi_s,
  output logic tdo,
  output logic tdo_oe_n
);
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UP_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UP_IR
  } tap_state_type;

  tap_state_type state_r, state_nxt;
  logic tck_d_r;
  logic [TAP_IR_W-1:0] ir_r, ir_sh_r;
  logic bypass_r;
  wire tck_rise = tck_s & ~tck_d_r;
  wire tck_fall = ~tck_s & tck_d_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TLR: state_nxt = tms_s ? TLR : RTI;
      RTI: state_nxt = tms_s ? SEL_DR : RTI;
      SEL_DR: state_nxt = tms_s ? SEL_IR : CAP_DR;
      CAP_DR: state_nxt = tms_s ? EX1_DR : SH_DR;
      SH_DR: state_nxt = tms_s ? EX1_DR : SH_DR;
      EX1_DR: state_nxt = tms_s ? UP_DR : PA_DR;
      PA_DR: state_nxt = tms_s ? EX2_DR : PA_DR;
      EX2_DR: state_nxt = tms_s ? UP_DR : SH_DR;
      UP_DR: state_nxt = tms_s ? SEL_DR : RTI;
      SEL_IR: state_nxt = tms_s ? TLR : CAP_IR;
      CAP_IR: state_nxt = tms_s ? EX1_IR : SH_IR;
      SH_IR: state_nxt = tms_s ? EX1_IR : SH_IR;
      EX1_IR: state_nxt = tms_s ? UP_IR : PA_IR;
      PA_IR: state_nxt = tms_s ? EX2_IR : PA_IR;
      EX2_IR: state_nxt = tms_s ? UP_IR : SH_IR;
      UP_IR: state_nxt = tms_s ? SEL_DR : RTI;
      default: state_nxt = TLR;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= TLR;
      tck_d_r <= 1'b0;
      ir_r <= TAP_IR_RESET;
      ir_sh_r <= TAP_IR_RESET;
      bypass_r <= 1'b0;
      tdo <= 1'b1;
      tdo_oe_n <= 1'b1;
    end else if (clk_en) begin
      tck_d_r <= tck_s;
      if (tck_rise) begin
        state_r <= state_nxt;
        if (state_r == TLR) ir_r <= TAP_IR_RESET;
        if (state_r == CAP_IR) ir_sh_r <= TAP_IR_CAPTURE;
        if (state_r == SH_IR) ir_sh_r <= {tdi_s, ir_sh_r[TAP_IR_W-1:1]};
        if (state_r == UP_IR) ir_r <= ir_sh_r;
        if (state_r == CAP_DR) bypass_r <= 1'b0;
        if (state_r == SH_DR) bypass_r <= tdi_s;
      end
      if (tck_fall) begin
        // TDO changes on the falling edge, as the standard requires
        tdo <= (state_r == SH_IR) ? ir_sh_r[0] : bypass_r;
        tdo_oe_n <= !(state_r == SH_IR || state_r == SH_DR);
      end
    end
  end
endmodule : jtag_tap
`default_nettype wire

// ===== hw/config_prom_output_sequencer.sv
/*
  Output sequencer of a configuration memory: address counter, revisions,
  cascade enable, busy flow control and gated configuration clock.
  Assumes all pins are asynchronous to clk and pass two flip-flops.
*/
`default_nettype none
// Contract
// - Cascade low when enabled and exhausted or missing
// - Cascade high on reset low or select high
// - Pin enable low: revision from pins
// - Pin enable high: revision from control bits
// - Revision is a two-bit field
// - Undriven revision pins read as one
// - Busy honoured only in parallel mode
// - Busy high freezes counter and data
// - After busy falls, next data on edge
// - Serial or decompression ignores busy
// - Undriven busy reads as zero
// - Clock output gated by enable bit, selected source
// - Advance on source edge when data, enabled
// - New data valid at clock output rise
// - Clock output high-Z when disabled
// - Decompression parks clock output high
// - Tap follows TMS on TCK rise
// - Test logic clocked by TCK (the TAP here runs on clk and steps on synchronised TCK edges)
// - TDI shifts into selected register
// - TDO shows selected register output
// - Reset low holds counter, outputs high-Z
// - Select high: standby, counter reset, high-Z
// - Pulse rise loads revision start address
// - External clock rise advances when allowed
module config_prom_output_sequencer
  import cfg_seq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Configuration pins
  input wire logic chip_select_n,
  input wire logic oe_reset_n,
  input wire logic config_pulse_n,
  input wire logic busy,
  input wire logic busy_driven,
  input wire logic ext_clock,
  input wire logic pin_revision_choice_enable,
  input wire logic revision_pin_bit0,
  input wire logic revision_pin_bit1,
  input wire logic [1:0] revision_pin_driven,
  // Programmed control bits
  input wire logic parallel_mode,
  input wire logic decompress_en,
  input wire logic clock_out_en,
  input wire logic use_ext_clock,
  input wire logic [cfg_seq_pkg::REV_W-1:0] revision_ctrl,
  input wire logic [cfg_seq_pkg::REV_N-1:0] revision_present,
  input wire logic [cfg_seq_pkg::REV_N*cfg_seq_pkg::ADDR_W-1:0] revision_start,
  input wire logic [cfg_seq_pkg::REV_N*cfg_seq_pkg::ADDR_W-1:0] last_address_limit,
  // Memory write port for the stored bitstream
  input wire logic mem_we,
  input wire logic [cfg_seq_pkg::ADDR_W-1:0] mem_waddr,
  input wire logic [cfg_seq_pkg::DATA_W-1:0] mem_wdata,
  // Outputs toward the FPGA and next memory
  output logic [cfg_seq_pkg::DATA_W-1:0] data_out,
  output logic data_oe_n,
  output logic config_clock_output,
  output logic config_clock_oe_n,
  output logic cascade_enable_out_n,
  output logic [cfg_seq_pkg::ADDR_W-1:0] address,
  // Test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n
);
  import cfg_seq_pkg::*;

  function automatic logic [ADDR_W-1:0] field(input logic [REV_N*ADDR_W-1:0] v, input logic [REV_W-1:0] i);
    field = v[i*ADDR_W +: ADDR_W];
  endfunction : field

  logic [DATA_W-1:0] mem [MEM_DEPTH];
  // Two-stage synchronisers; only stage two is read by logic
  logic [SYNC_STAGES-1:0] cs_s, oe_s, cf_s, busy_s, ec_s, pe_s, r0_s, r1_s, tck_ss, tms_ss, tdi_ss;
  logic cf_d_r, ec_d_r, busy_d_r, src_d_r, pend_r;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [REV_W-1:0] rev_r;
  logic [DATA_W-1:0] data_r;
  logic done_r;
  logic [3:0] dcnt_r;
  logic osc_r;
  logic ceo_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s <= '1;
      oe_s <= '0;
      cf_s <= '1;
      busy_s <= '0;
      ec_s <= '0;
      pe_s <= '1;
      r0_s <= '1;
      r1_s <= '1;
      tck_ss <= '0;
      tms_ss <= '1;
      tdi_ss <= '1;
    end else if (clk_en) begin
      cs_s <= {cs_s[0], chip_select_n};
      oe_s <= {oe_s[0], oe_reset_n};
      cf_s <= {cf_s[0], config_pulse_n};
      busy_s <= {busy_s[0], busy & busy_driven};
      ec_s <= {ec_s[0], ext_clock};
      pe_s <= {pe_s[0], pin_revision_choice_enable};
      r0_s <= {r0_s[0], revision_pin_bit0 | ~revision_pin_driven[0]};
      r1_s <= {r1_s[0], revision_pin_bit1 | ~revision_pin_driven[1]};
      tck_ss <= {tck_ss[0], tck};
      tms_ss <= {tms_ss[0], tms};
      tdi_ss <= {tdi_ss[0], tdi};
    end
  end

  wire cs_n = cs_s[1];
  wire oe_n_low = ~oe_s[1];
  wire active = ~cs_n & ~oe_n_low;
  // Pins win while the choice enable is low
  wire [REV_W-1:0] rev_sel = pe_s[1] ? revision_ctrl : {r1_s[1], r0_s[1]};
  wire cf_rise = cf_s[1] & ~cf_d_r;
  wire busy_eff = busy_s[1] & parallel_mode & ~decompress_en;
  wire busy_fell = busy_d_r & ~busy_s[1];
  // Internal oscillator is clk divided by two
  wire src_lvl = use_ext_clock ? ec_s[1] : osc_r;
  wire src_rise = src_lvl & ~src_d_r;
  wire data_ready = ~decompress_en | (dcnt_r == 4'h0);
  wire rev_ok = revision_present[rev_r];
  wire avail = rev_ok & ~done_r & data_ready;
  wire advance = src_rise & active & cf_s[1] & avail & ~busy_eff;
  wire at_limit = (addr_r == field(last_address_limit, rev_r));
  wire ceo_nxt = ~(active & (done_r | ~rev_ok));
  wire clk_on = clock_out_en & active;

  always_comb begin
    addr_nxt = addr_r;
    if (!active) begin
      addr_nxt = ADDR_RESET;
    end else if (cf_rise) begin
      addr_nxt = field(revision_start, rev_sel);
    end else if (advance && !at_limit) begin
      addr_nxt = addr_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cf_d_r <= 1'b1;
      ec_d_r <= 1'b0;
      busy_d_r <= 1'b0;
      src_d_r <= 1'b0;
      osc_r <= 1'b0;
      pend_r <= 1'b0;
    end else if (clk_en) begin
      cf_d_r <= cf_s[1];
      ec_d_r <= ec_s[1];
      busy_d_r <= busy_s[1];
      src_d_r <= src_lvl;
      osc_r <= ~osc_r;
      // A falling busy arms a data reload that stays armed until the next source edge
      if (busy_fell) pend_r <= 1'b1;
      else if (src_rise) pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= ADDR_RESET;
      rev_r <= REV_CTRL_RESET;
      done_r <= 1'b0;
    end else if (clk_en) begin
      addr_r <= addr_nxt;
      if (cf_rise) rev_r <= rev_sel;
      if (!active || cf_rise) done_r <= 1'b0;
      else if (advance && at_limit) done_r <= 1'b1;
    end
  end

  // Decompression latency models the decompressor's fetch time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dcnt_r <= 4'h0;
    end else if (clk_en) begin
      if (!decompress_en || !active) dcnt_r <= 4'h0;
      else if (advance) dcnt_r <= DECOMP_CYC_W;
      else if (dcnt_r != 4'h0) dcnt_r <= dcnt_r - 4'h1;
    end
  end

  // Writes obey the clock enable too, so a frozen block keeps its image
  always_ff @(posedge clk) begin
    if (clk_en && mem_we) mem[mem_waddr] <= mem_wdata;
  end

  // Data follows the counter; launched with the source rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_r <= DATA_RESET;
      ceo_r <= 1'b1;
    end else if (clk_en) begin
      if (!busy_eff || pend_r) data_r <= mem[addr_nxt];
      ceo_r <= ceo_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config_clock_output <= 1'b1;
      config_clock_oe_n <= 1'b1;
      data_oe_n <= 1'b1;
    end else if (clk_en) begin
      config_clock_oe_n <= ~clk_on;
      config_clock_output <= (decompress_en && !data_ready) ? 1'b1 : src_lvl;
      data_oe_n <= ~active;
    end
  end

  assign data_out = data_r;
  assign cascade_enable_out_n = ceo_r;
  assign address = addr_r;

  jtag_tap u_tap (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .tck_s(tck_ss[1]),
    .tms_s(tms_ss[1]),
    .tdi_s(tdi_ss[1]),
    .tdo(tdo),
    .tdo_oe_n(tdo_oe_n)
  );

  cascade_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !ceo_nxt) |=> !cascade_enable_out_n)
    else $error("cascade enable not low");
  cascade_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !active) |=> cascade_enable_out_n)
    else $error("cascade enable not released");
  rev_pins_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && cf_rise && !pe_s[1]) |=> rev_r == $past({r1_s[1], r0_s[1]}))
    else $error("revision not from pins");
  rev_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && cf_rise && pe_s[1]) |=> rev_r == $past(revision_ctrl))
    else $error("revision not from control bits");
  busy_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && busy_eff && active && !cf_rise) |=> $stable(addr_r))
    else $error("counter moved under busy");
  busy_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
    (busy_s[1] && decompress_en) |-> !busy_eff)
    else $error("busy honoured with decompression");
  clk_hiz_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !active) |=> config_clock_oe_n && data_oe_n)
    else $error("outputs driven while disabled");
  reset_ctr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !active) |=> addr_r == ADDR_RESET)
    else $error("counter not held in reset");
  start_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && active && cf_rise) |=> addr_r == $past(field(revision_start, rev_sel)))
    else $error("start address not loaded");
  park_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && decompress_en && !data_ready) |=> config_clock_output)
    else $error("clock output not parked high");
  busy_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    (busy_s[1] && !parallel_mode) |-> !busy_eff)
    else $error("busy honoured outside parallel mode");
  busy_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && busy_eff && !pend_r) |=> $stable(data_out))
    else $error("data moved under busy");
  resume_next_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && busy_fell && advance && !at_limit && !cf_rise) |=> addr_r == $past(addr_r) + 16'h0001)
    else $error("no advance after busy fell");
  clk_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !clock_out_en) |=> config_clock_oe_n)
    else $error("clock output driven while not enabled");
  clk_src_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !decompress_en) |=> config_clock_output == $past(src_lvl))
    else $error("clock output not from source");
  osc_run_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en |=> osc_r != $past(osc_r))
    else $error("oscillator stalled");
  advance_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && advance && !at_limit && !cf_rise) |=> addr_r == $past(addr_r) + 16'h0001)
    else $error("counter did not advance");
  no_advance_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && active && !cf_rise && !advance) |=> $stable(addr_r))
    else $error("counter moved without advance");
  standby_ctr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && cs_n) |=> addr_r == ADDR_RESET)
    else $error("counter not reset in standby");
  data_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && active) |=> !data_oe_n)
    else $error("data not driven while enabled");
  oe_hiz_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && oe_n_low) |=> config_clock_oe_n && data_oe_n)
    else $error("outputs driven in reset");
  done_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && done_r && active && !cf_rise) |=> $stable(addr_r))
    else $error("counter moved past limit");
  no_rev_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && active && !rev_ok) |=> !cascade_enable_out_n)
    else $error("cascade high with missing revision");
  cascade_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && active && rev_ok && !done_r) |=> cascade_enable_out_n)
    else $error("cascade low too early");
  rev_field_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && cf_rise && !pe_s[1]) |=> rev_r[1] == $past(r1_s[1]))
    else $error("revision high bit wrong");
  pin0_float_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !revision_pin_driven[0]) |=> r0_s[0])
    else $error("undriven pin zero not one");
  pin1_float_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !revision_pin_driven[1]) |=> r1_s[0])
    else $error("undriven pin one not one");
  busy_float_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !busy_driven) |=> !busy_s[0])
    else $error("undriven busy not zero");
  decomp_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && decompress_en && advance) |=> !data_ready)
    else $error("decompressed data ready too early");
  limit_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && advance && at_limit && !cf_rise) |=> done_r)
    else $error("limit not flagged");
  start_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && cf_rise) |=> !done_r)
    else $error("done not cleared on load");
endmodule : config_prom_output_sequencer
`default_nettype wire

// ===== dv/fpga_cfg_model.sv
/*
  Behavioural model of the FPGA that takes the configuration stream.
  Assumes the configuration clock output and data bus are already resolved.
*/
`default_nettype none
module fpga_cfg_model (
  // Stream from the memory
  input wire logic cfg_clk,
  input wire logic [7:0] data_in,
  // Flow control request from the bench
  input wire logic hold_busy,
  output logic busy,
  // Observations
  output logic [7:0] last_byte,
  output int rises
);
  timeunit 1ns;
  timeprecision 100ps;
  // Busy is a plain level held as long as the bench asks
  assign busy = hold_busy;
  initial begin
    rises = 0;
    last_byte = 8'h00;
  end
  // Data is taken on the rising edge of the clock output
  always @(posedge cfg_clk) begin
    last_byte <= data_in;
    rises <= rises + 1;
  end
endmodule : fpga_cfg_model
`default_nettype wire

// ===== dv/tb.sv
/*
  Self-checking bench for the configuration output sequencer.
  Assumes the design synchronises pins in two flops, as noted.
*/
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import cfg_seq_pkg::*;
  logic clk, rst_n, cs_n, oe_n, pulse_n, busy, busy_drv, ext_clk, pin_en, rb0, rb1;
  logic [1:0] rb_drv;
  logic par, dec, ck_en, use_ext, hold_busy, we, tck_p, tms_p, tdi_p;
  logic [REV_W-1:0] rev_ctrl;
  logic [REV_N-1:0] present;
  logic [REV_N*ADDR_W-1:0] starts, limits;
  logic [ADDR_W-1:0] waddr, address;
  logic [DATA_W-1:0] wdata, data_out, last_byte;
  logic data_oe_n, cko, cko_oe_n, casc_n, tdo, tdo_oe_n;
  int num_errors = 0;
  int checks = 0;
  int rises;
  config_prom_output_sequencer i_dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .chip_select_n(cs_n),
    .oe_reset_n(oe_n), .config_pulse_n(pulse_n), .busy(busy), .busy_driven(busy_drv), .ext_clock(ext_clk),
    .pin_revision_choice_enable(pin_en), .revision_pin_bit0(rb0), .revision_pin_bit1(rb1),
    .revision_pin_driven(rb_drv), .parallel_mode(par), .decompress_en(dec), .clock_out_en(ck_en),
    .use_ext_clock(use_ext), .revision_ctrl(rev_ctrl), .revision_present(present), .revision_start(starts),
    .last_address_limit(limits), .mem_we(we), .mem_waddr(waddr), .mem_wdata(wdata), .data_out(data_out),
    .data_oe_n(data_oe_n), .config_clock_output(cko), .config_clock_oe_n(cko_oe_n),
    .cascade_enable_out_n(casc_n), .address(address), .tck(tck_p), .tms(tms_p), .tdi(tdi_p), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n));
  fpga_cfg_model i_fpga (.cfg_clk(cko), .data_in(data_out), .hold_busy(hold_busy), .busy(busy),
    .last_byte(last_byte), .rises(rises));
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ 8'ha5;
  endfunction : pat
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  // Source pulses span several clk so the two-flop sync sees each level
  task automatic ext_edge(input int n);
    repeat (n) begin
      ext_clk = 1'b1;
      tick(4);
      ext_clk = 1'b0;
      tick(4);
    end
  endtask : ext_edge
  task automatic jtag_step(input logic m, input logic d);
    tms_p = m;
    tdi_p = d;
    tck_p = 1'b1;
    tick(4);
    tck_p = 1'b0;
    tick(4);
  endtask : jtag_step
  task automatic load();
    pulse_n = 1'b0;
    tick(4);
    pulse_n = 1'b1;
    tick(6);
  endtask : load
  task automatic conclude();
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 20000);
    num_errors++;
    conclude();
  end
  initial begin
    rst_n = 1'b0; cs_n = 1'b0; oe_n = 1'b1; pulse_n = 1'b1; busy_drv = 1'b1; ext_clk = 1'b0;
    pin_en = 1'b0; rb1 = 1'b1; rb0 = 1'b0; rb_drv = 2'h3; par = 1'b0; dec = 1'b0; ck_en = 1'b0;
    use_ext = 1'b1; hold_busy = 1'b0; we = 1'b0; rev_ctrl = 2'h1; present = 4'he;
    waddr = 16'h0000; wdata = 8'h00; tck_p = 1'b0; tms_p = 1'b1; tdi_p = 1'b1;
    starts = {16'h0030, 16'h0020, 16'h0010, 16'h0000};
    limits = {16'h003f, 16'h002f, 16'h0013, 16'h000f};
    tick(5);
    `CHK(address, 16'h0000)
    `CHK({data_oe_n, cko_oe_n, casc_n}, 3'h7)
    rst_n = 1'b1;
    tick(4);
    // Bitstream image: one byte per address
    for (int a = 0; a < 64; a++) begin
      we = 1'b1; waddr = 16'(a); wdata = pat(16'(a));
      tick(1);
    end
    we = 1'b0;
    load();
    `CHK(address, 16'h0020)
    `CHK(data_oe_n, 1'b0)
    ext_edge(3);
    `CHK(address, 16'h0023)
    `CHK(data_out, pat(16'h0023))
    par = 1'b1; hold_busy = 1'b1;
    ext_edge(2);
    `CHK(address, 16'h0023)
    `CHK(data_out, pat(16'h0023))
    hold_busy = 1'b0;
    ext_edge(1);
    `CHK(data_out, pat(16'h0024))
    hold_busy = 1'b1; busy_drv = 1'b0;
    ext_edge(1);
    `CHK(address, 16'h0025)
    busy_drv = 1'b1; par = 1'b0;
    ext_edge(1);
    `CHK(address, 16'h0026)
    hold_busy = 1'b0; pin_en = 1'b1; rb1 = 1'b0;
    load();
    `CHK(address, 16'h0010)
    ext_edge(5);
    `CHK(address, 16'h0013)
    `CHK(casc_n, 1'b0)
    cs_n = 1'b1;
    tick(6);
    `CHK(casc_n, 1'b1)
    `CHK({address, data_oe_n}, {16'h0000, 1'b1})
    `CHK(cko_oe_n, 1'b1)
    cs_n = 1'b0; pin_en = 1'b0; rb_drv = 2'h0;
    load();
    `CHK(address, 16'h0030)
    rb_drv = 2'h3;
    load();
    `CHK(casc_n, 1'b0)
    rb1 = 1'b1; rb0 = 1'b1;
    load();
    dec = 1'b1; par = 1'b1; hold_busy = 1'b1;
    ext_edge(2);
    `CHK(address, 16'h0032)
    dec = 1'b0; par = 1'b0; hold_busy = 1'b0;
    ck_en = 1'b1; use_ext = 1'b0;
    tick(20);
    `CHK(cko_oe_n, 1'b0)
    `CHK(rises > 0, 1'b1)
    `CHK(address > 16'h0030, 1'b1)
    oe_n = 1'b0;
    tick(6);
    `CHK(cko_oe_n, 1'b1)
    `CHK(address, 16'h0000)
    `CHK(casc_n, 1'b1)
    `CHK({tdo_oe_n, tdo}, 2'h3)
    jtag_step(1'b0, 1'b1);
    jtag_step(1'b1, 1'b1);
    jtag_step(1'b1, 1'b1);
    jtag_step(1'b0, 1'b1);
    jtag_step(1'b0, 1'b0);
    `CHK({tdo_oe_n, tdo}, 2'h1)
    jtag_step(1'b0, 1'b0);
    `CHK({tdo_oe_n, tdo}, 2'h0)
    conclude();
  end
endmodule : tb
`undef CHK
`default_nettype wire
